// ---- rtl/cpu_exec_pkg.sv ----
package cpu_exec_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int RNUM_W = 5;
	localparam int NUM_REGS = 32;

	// ----------------------------------------
	// flag register bit positions
	// ----------------------------------------
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [7:0]  REG_RST   = 8'h00;
	localparam logic [15:0] STACK_TOP_DFLT = 16'h01FF;

	// ----------------------------------------
	// register numbers: R0, R1 and the low byte of each pointer pair
	// ----------------------------------------
	localparam logic [4:0] REG_R0   = 5'h00;
	localparam logic [4:0] REG_R1   = 5'h01;
	localparam logic [4:0] REG_X_LO = 5'h1A;
	localparam logic [4:0] REG_Y_LO = 5'h1C;
	localparam logic [4:0] REG_Z_LO = 5'h1E;

	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;

	localparam logic [1:0] PM_PLAIN = 2'h0;
	localparam logic [1:0] PM_INC   = 2'h1;
	localparam logic [1:0] PM_DEC   = 2'h2;

	// ----------------------------------------
	// decoded operations and sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NOP          = 5'h00,
		OP_FLAG_RAISE   = 5'h01,
		OP_FLAG_LOWER   = 5'h02,
		OP_T_CAPTURE    = 5'h03,
		OP_T_DEPOSIT    = 5'h04,
		OP_COPY_BYTE    = 5'h05,
		OP_COPY_PAIR    = 5'h06,
		OP_IMM_LOAD     = 5'h07,
		OP_IND_READ     = 5'h08,
		OP_DISP_READ    = 5'h09,
		OP_DIR_READ     = 5'h0A,
		OP_IND_WRITE    = 5'h0B,
		OP_DISP_WRITE   = 5'h0C,
		OP_DIR_WRITE    = 5'h0D,
		OP_CODE_READ    = 5'h0E,
		OP_CODE_READ_R0 = 5'h0F,
		OP_CODE_WRITE   = 5'h10,
		OP_PUSH         = 5'h11,
		OP_POP          = 5'h12,
		OP_SLEEP        = 5'h13,
		OP_WDOG         = 5'h14,
		OP_BREAK        = 5'h15
	} op_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_MEM   = 6'h02,
		ST_CODE1 = 6'h04,
		ST_CODE2 = 6'h08,
		ST_CWAIT = 6'h10,
		ST_HALT  = 6'h20
	} state_t;

endpackage

// ---- rtl/flag_move_exec.sv ----
`timescale 1ns/10ps
module flag_move_exec #(
	parameter logic [15:0] STACK_TOP = cpu_exec_pkg::STACK_TOP_DFLT
) (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	// instruction issue
	input  wire logic        ISSUE,
	input  wire logic [4:0]  OPCODE,
	input  wire logic [4:0]  DST,
	input  wire logic [4:0]  SRC,
	input  wire logic [2:0]  BITSEL,
	input  wire logic [7:0]  IMM,
	input  wire logic [5:0]  DISP,
	input  wire logic [15:0] ADDR,
	input  wire logic [1:0]  PTR,
	input  wire logic [1:0]  PTRMODE,
	output logic             READY,
	// data memory
	output logic [15:0]      DMEM_ADDR,
	output logic [7:0]       DMEM_WDATA,
	output logic             DMEM_WE,
	output logic             DMEM_RE,
	input  wire logic [7:0]  DMEM_RDATA,
	// code memory
	output logic [15:0]      CMEM_ADDR,
	output logic [15:0]      CMEM_WDATA,
	output logic             CMEM_RE,
	output logic             CMEM_WE,
	input  wire logic [7:0]  CMEM_RDATA,
	input  wire logic        CMEM_DONE,
	// state and control events
	output logic [7:0]       FLAGS,
	output logic [15:0]      STACK_PTR,
	output logic             SLEEP_REQ,
	output logic             WDOG_RESTART,
	output logic             DEBUG_BREAK,
	input  wire logic        DEBUG_RESUME,
	// register file write trace
	output logic             REG_WE,
	output logic             REG_PAIR,
	output logic [4:0]       REG_NUM,
	output logic [15:0]      REG_DATA
);

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (STACK_TOP == 16'h0000) begin : g_bad_stack
		$error("stack top must leave room for a push");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [4:0] ptr_base(input logic [1:0] sel);
		ptr_base = (sel == cpu_exec_pkg::PTR_X) ? cpu_exec_pkg::REG_X_LO :
			(sel == cpu_exec_pkg::PTR_Y) ? cpu_exec_pkg::REG_Y_LO :
			cpu_exec_pkg::REG_Z_LO;
	endfunction

	// address used by the access: pre-decrement moves first
	function automatic logic [15:0] eff_addr(input logic [15:0] p,
			input logic [1:0] mode);
		eff_addr = (mode == cpu_exec_pkg::PM_DEC) ? 16'(p - 16'h0001) : p;
	endfunction

	// pointer value left behind after the access
	function automatic logic [15:0] ptr_after(input logic [15:0] p,
			input logic [1:0] mode);
		ptr_after = (mode == cpu_exec_pkg::PM_INC) ? 16'(p + 16'h0001) :
			(mode == cpu_exec_pkg::PM_DEC) ? 16'(p - 16'h0001) : p;
	endfunction

	// ----------------------------------------
	// storage and decode signals
	// ----------------------------------------
	cpu_exec_pkg::op_t    op;
	cpu_exec_pkg::state_t state_q, state_d;
	logic [7:0]  rf_q [cpu_exec_pkg::NUM_REGS];
	logic [7:0]  flags_q, flags_d;
	logic [15:0] sp_q, sp_d;
	logic [4:0]  ld_dst_q, ld_dst_d;
	logic [4:0]  base;
	logic [4:0]  zbase;
	logic [15:0] ptr;
	logic [15:0] zptr;
	logic [15:0] dm_addr_d, cm_addr_d, cm_wdata_d;
	logic [7:0]  dm_wdata_d;
	logic        dm_re_d, dm_we_d, cm_re_d, cm_we_d;
	logic        sleep_d, wdog_d, brk_d;
	logic        rf_we, rf_pair;
	logic [4:0]  rf_waddr;
	logic [15:0] rf_wdata;
	logic [7:0]  src_byte, dst_byte;
	logic        iss;

	assign op       = cpu_exec_pkg::op_t'(OPCODE);
	assign iss      = ISSUE && READY;
	assign base     = ptr_base(PTR);
	assign zbase    = cpu_exec_pkg::REG_Z_LO;
	assign ptr      = {rf_q[5'(base + 5'h01)], rf_q[base]};
	assign zptr     = {rf_q[5'(zbase + 5'h01)], rf_q[zbase]};
	assign src_byte = rf_q[SRC];
	assign dst_byte = rf_q[DST];

	// ----------------------------------------
	// execution decode
	// ----------------------------------------
	always_comb begin
		state_d    = state_q;
		flags_d    = flags_q;
		sp_d       = sp_q;
		ld_dst_d   = ld_dst_q;
		dm_addr_d  = DMEM_ADDR;
		dm_wdata_d = DMEM_WDATA;
		cm_addr_d  = CMEM_ADDR;
		cm_wdata_d = CMEM_WDATA;
		dm_re_d    = 1'b0;
		dm_we_d    = 1'b0;
		cm_re_d    = 1'b0;
		cm_we_d    = 1'b0;
		sleep_d    = 1'b0;
		wdog_d     = 1'b0;
		brk_d      = 1'b0;
		rf_we      = 1'b0;
		rf_pair    = 1'b0;
		rf_waddr   = DST;
		rf_wdata   = 16'h0000;
		unique case (state_q)
			cpu_exec_pkg::ST_IDLE: if (ISSUE) begin
				case (op)
					cpu_exec_pkg::OP_FLAG_RAISE:
						flags_d[BITSEL] = 1'b1;
					cpu_exec_pkg::OP_FLAG_LOWER:
						flags_d[BITSEL] = 1'b0;
					cpu_exec_pkg::OP_T_CAPTURE:
						flags_d[cpu_exec_pkg::FLAG_T] = src_byte[BITSEL];
					cpu_exec_pkg::OP_T_DEPOSIT: begin
						rf_we    = 1'b1;
						rf_wdata = {8'h00, dst_byte};
						rf_wdata[BITSEL] = flags_q[cpu_exec_pkg::FLAG_T];
					end
					cpu_exec_pkg::OP_COPY_BYTE: begin
						rf_we    = 1'b1;
						rf_wdata = {8'h00, src_byte};
					end
					cpu_exec_pkg::OP_COPY_PAIR: begin
						rf_we    = 1'b1;
						rf_pair  = 1'b1;
						rf_wdata = {rf_q[5'(SRC + 5'h01)], src_byte};
					end
					cpu_exec_pkg::OP_IMM_LOAD: begin
						rf_we    = 1'b1;
						rf_wdata = {8'h00, IMM};
					end
					cpu_exec_pkg::OP_IND_READ,
					cpu_exec_pkg::OP_IND_WRITE: begin
						dm_addr_d = eff_addr(ptr, PTRMODE);
						dm_re_d   = (op == cpu_exec_pkg::OP_IND_READ);
						dm_we_d   = (op == cpu_exec_pkg::OP_IND_WRITE);
						dm_wdata_d = src_byte;
						ld_dst_d  = DST;
						rf_we     = (PTRMODE != cpu_exec_pkg::PM_PLAIN);
						rf_pair   = 1'b1;
						rf_waddr  = base;
						rf_wdata  = ptr_after(ptr, PTRMODE);
						state_d   = cpu_exec_pkg::ST_MEM;
					end
					cpu_exec_pkg::OP_DISP_READ,
					cpu_exec_pkg::OP_DISP_WRITE: begin
						dm_addr_d  = 16'(ptr + {10'h000, DISP});
						dm_re_d    = (op == cpu_exec_pkg::OP_DISP_READ);
						dm_we_d    = (op == cpu_exec_pkg::OP_DISP_WRITE);
						dm_wdata_d = src_byte;
						ld_dst_d   = DST;
						state_d    = cpu_exec_pkg::ST_MEM;
					end
					cpu_exec_pkg::OP_DIR_READ,
					cpu_exec_pkg::OP_DIR_WRITE: begin
						dm_addr_d  = ADDR;
						dm_re_d    = (op == cpu_exec_pkg::OP_DIR_READ);
						dm_we_d    = (op == cpu_exec_pkg::OP_DIR_WRITE);
						dm_wdata_d = src_byte;
						ld_dst_d   = DST;
						state_d    = cpu_exec_pkg::ST_MEM;
					end
					cpu_exec_pkg::OP_PUSH: begin
						dm_addr_d  = sp_q;
						dm_we_d    = 1'b1;
						dm_wdata_d = src_byte;
						sp_d       = 16'(sp_q - 16'h0001);
						state_d    = cpu_exec_pkg::ST_MEM;
					end
					cpu_exec_pkg::OP_POP: begin
						sp_d      = 16'(sp_q + 16'h0001);
						dm_addr_d = 16'(sp_q + 16'h0001);
						dm_re_d   = 1'b1;
						ld_dst_d  = DST;
						state_d   = cpu_exec_pkg::ST_MEM;
					end
					cpu_exec_pkg::OP_CODE_READ,
					cpu_exec_pkg::OP_CODE_READ_R0: begin
						cm_addr_d = zptr;
						cm_re_d   = 1'b1;
						ld_dst_d  = (op == cpu_exec_pkg::OP_CODE_READ_R0) ?
							cpu_exec_pkg::REG_R0 : DST;
						rf_we     = (op == cpu_exec_pkg::OP_CODE_READ) &&
							(PTRMODE == cpu_exec_pkg::PM_INC);
						rf_pair   = 1'b1;
						rf_waddr  = zbase;
						rf_wdata  = 16'(zptr + 16'h0001);
						state_d   = cpu_exec_pkg::ST_CODE1;
					end
					cpu_exec_pkg::OP_CODE_WRITE: begin
						cm_addr_d  = zptr;
						cm_wdata_d = {rf_q[cpu_exec_pkg::REG_R1],
							rf_q[cpu_exec_pkg::REG_R0]};
						cm_we_d    = 1'b1;
						state_d    = cpu_exec_pkg::ST_CWAIT;
					end
					cpu_exec_pkg::OP_SLEEP:
						sleep_d = 1'b1;
					cpu_exec_pkg::OP_WDOG:
						wdog_d = 1'b1;
					cpu_exec_pkg::OP_BREAK: begin
						brk_d   = 1'b1;
						state_d = cpu_exec_pkg::ST_HALT;
					end
					default: ;
				endcase
			end
			cpu_exec_pkg::ST_MEM: begin
				// load data lands one cycle after the address
				rf_we    = DMEM_RE;
				rf_waddr = ld_dst_q;
				rf_wdata = {8'h00, DMEM_RDATA};
				state_d  = cpu_exec_pkg::ST_IDLE;
			end
			cpu_exec_pkg::ST_CODE1:
				state_d = cpu_exec_pkg::ST_CODE2;
			cpu_exec_pkg::ST_CODE2: begin
				rf_we    = 1'b1;
				rf_waddr = ld_dst_q;
				rf_wdata = {8'h00, CMEM_RDATA};
				state_d  = cpu_exec_pkg::ST_IDLE;
			end
			cpu_exec_pkg::ST_CWAIT:
				// flash programming time is open-ended
				if (CMEM_DONE) state_d = cpu_exec_pkg::ST_IDLE;
			cpu_exec_pkg::ST_HALT:
				if (DEBUG_RESUME) state_d = cpu_exec_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// sequencing and flags
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			state_q  <= cpu_exec_pkg::ST_IDLE;
			flags_q  <= cpu_exec_pkg::FLAGS_RST;
			sp_q     <= STACK_TOP;
			ld_dst_q <= cpu_exec_pkg::REG_R0;
		end else begin
			state_q  <= state_d;
			flags_q  <= flags_d;
			sp_q     <= sp_d;
			ld_dst_q <= ld_dst_d;
		end
	end

	// ----------------------------------------
	// register file, pairs written in one edge
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < cpu_exec_pkg::NUM_REGS; i++) begin
				rf_q[i] <= cpu_exec_pkg::REG_RST;
			end
		end else if (rf_we) begin
			rf_q[rf_waddr] <= rf_wdata[7:0];
			if (rf_pair) rf_q[5'(rf_waddr + 5'h01)] <= rf_wdata[15:8];
		end
	end

	// ----------------------------------------
	// memory ports and event pulses
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			DMEM_ADDR    <= 16'h0000;
			DMEM_WDATA   <= 8'h00;
			DMEM_WE      <= 1'b0;
			DMEM_RE      <= 1'b0;
			CMEM_ADDR    <= 16'h0000;
			CMEM_WDATA   <= 16'h0000;
			CMEM_RE      <= 1'b0;
			CMEM_WE      <= 1'b0;
			SLEEP_REQ    <= 1'b0;
			WDOG_RESTART <= 1'b0;
			DEBUG_BREAK  <= 1'b0;
		end else begin
			DMEM_ADDR    <= dm_addr_d;
			DMEM_WDATA   <= dm_wdata_d;
			DMEM_WE      <= dm_we_d;
			DMEM_RE      <= dm_re_d;
			CMEM_ADDR    <= cm_addr_d;
			CMEM_WDATA   <= cm_wdata_d;
			CMEM_RE      <= cm_re_d;
			CMEM_WE      <= cm_we_d;
			SLEEP_REQ    <= sleep_d;
			WDOG_RESTART <= wdog_d;
			DEBUG_BREAK  <= brk_d;
		end
	end

	// ----------------------------------------
	// register write trace
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			REG_WE   <= 1'b0;
			REG_PAIR <= 1'b0;
			REG_NUM  <= 5'h00;
			REG_DATA <= 16'h0000;
		end else begin
			REG_WE   <= rf_we;
			REG_PAIR <= rf_pair && rf_we;
			REG_NUM  <= rf_waddr;
			REG_DATA <= rf_wdata;
		end
	end

	assign READY     = state_q[0];
	assign FLAGS     = flags_q;
	assign STACK_PTR = sp_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	flag_raise_a: assert property (
		iss && op == cpu_exec_pkg::OP_FLAG_RAISE |=>
		FLAGS == ($past(FLAGS) | (8'h01 << $past(BITSEL))) && READY)
		else $error("flag raise changed other bits or stalled");

	irq_enable_a: assert property (
		iss && op == cpu_exec_pkg::OP_FLAG_LOWER &&
		BITSEL == cpu_exec_pkg::FLAG_I |=> !FLAGS[cpu_exec_pkg::FLAG_I])
		else $error("interrupt enable not cleared");

	half_carry_a: assert property (
		iss && op == cpu_exec_pkg::OP_FLAG_RAISE &&
		BITSEL == cpu_exec_pkg::FLAG_H |=>
		FLAGS[cpu_exec_pkg::FLAG_H] &&
		FLAGS[4:0] == $past(FLAGS[4:0]))
		else $error("half-carry raise wrong");

	t_capture_a: assert property (
		iss && op == cpu_exec_pkg::OP_T_CAPTURE |=>
		FLAGS[cpu_exec_pkg::FLAG_T] == $past(src_byte[BITSEL]) &&
		FLAGS[5:0] == $past(FLAGS[5:0]))
		else $error("T capture wrong");

	copy_flags_a: assert property (
		iss && (op == cpu_exec_pkg::OP_COPY_BYTE ||
		op == cpu_exec_pkg::OP_T_DEPOSIT ||
		op == cpu_exec_pkg::OP_IMM_LOAD) |=>
		REG_WE && READY && FLAGS == $past(FLAGS))
		else $error("copy not single cycle or touched flags");

	predec_read_a: assert property (
		iss && op == cpu_exec_pkg::OP_IND_READ &&
		PTRMODE == cpu_exec_pkg::PM_DEC |=>
		DMEM_RE && DMEM_ADDR == 16'($past(ptr) - 16'h0001) &&
		REG_DATA == DMEM_ADDR ##1 READY)
		else $error("pre-decrement read address wrong");

	postinc_write_a: assert property (
		iss && op == cpu_exec_pkg::OP_IND_WRITE &&
		PTRMODE == cpu_exec_pkg::PM_INC |=>
		DMEM_WE && DMEM_ADDR == $past(ptr) &&
		REG_DATA == 16'($past(ptr) + 16'h0001) ##1 READY)
		else $error("post-increment write wrong");

	disp_access_a: assert property (
		iss && (op == cpu_exec_pkg::OP_DISP_READ ||
		op == cpu_exec_pkg::OP_DISP_WRITE) |=>
		DMEM_ADDR == 16'($past(ptr) + {10'h000, $past(DISP)}) &&
		!READY ##1 READY)
		else $error("displaced access wrong");

	code_read_a: assert property (
		iss && op == cpu_exec_pkg::OP_CODE_READ_R0 |=>
		CMEM_RE && !READY ##1 !READY ##1 READY &&
		REG_WE && REG_NUM == cpu_exec_pkg::REG_R0)
		else $error("code read not three cycles into R0");

	push_timing_a: assert property (
		iss && op == cpu_exec_pkg::OP_PUSH |=>
		DMEM_WE && STACK_PTR == 16'($past(STACK_PTR) - 16'h0001)
		##1 READY && $stable(FLAGS))
		else $error("push timing wrong");

	wdog_pulse_a: assert property (
		iss && op == cpu_exec_pkg::OP_WDOG |=>
		WDOG_RESTART && READY ##1 (!WDOG_RESTART ||
		$past(iss && op == cpu_exec_pkg::OP_WDOG)))
		else $error("watchdog restart pulse wrong");

endmodule

// ---- tb/mem_partner.sv ----
`timescale 1ns/10ps
module mem_partner (
	// clock
	input  wire logic        CLOCK,
	// data memory side
	input  wire logic [15:0] DMEM_ADDR,
	input  wire logic [7:0]  DMEM_WDATA,
	input  wire logic        DMEM_WE,
	input  wire logic        DMEM_RE,
	output logic      [7:0]  DMEM_RDATA,
	// code memory side
	input  wire logic [15:0] CMEM_ADDR,
	input  wire logic        CMEM_RE,
	input  wire logic        CMEM_WE,
	output logic      [7:0]  CMEM_RDATA,
	output logic             CMEM_DONE,
	// pacing
	input  wire logic        slow
);
	// ----------------------------------------
	// storage and pacing state
	// ----------------------------------------
	logic [7:0] mem_q [256];
	logic [7:0] last_q = 8'h00;
	logic [7:0] crd_q  = 8'h00;
	logic [2:0] cnt_q  = 3'h0;

	initial for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'hA5;

	// ----------------------------------------
	// answers
	// ----------------------------------------
	// unread bus shows inverse of last value, so stale data cannot match
	assign DMEM_RDATA = DMEM_RE ? mem_q[DMEM_ADDR[7:0]] : ~last_q;
	assign CMEM_RDATA = crd_q;
	assign CMEM_DONE  = (cnt_q == 3'h1);

	always @(posedge CLOCK) begin
		if (DMEM_WE)
			mem_q[DMEM_ADDR[7:0]] <= DMEM_WDATA;
		if (DMEM_RE)
			last_q <= DMEM_RDATA;
		// code byte valid only in the cycle after the request
		crd_q <= CMEM_RE ? CMEM_ADDR[7:0] ^ CMEM_ADDR[15:8] ^ 8'h3C : ~crd_q;
		if (CMEM_WE)
			cnt_q <= slow ? 3'h4 : 3'h1;
		else if (cnt_q != 3'h0)
			cnt_q <= cnt_q - 3'h1;
	end
endmodule

// ---- tb/cpu_flag_move_control_ops_tb.sv ----
`timescale 1ns/10ps
module cpu_flag_move_control_ops_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        CLOCK = 1'b0, NRST = 1'b0, ISSUE = 1'b0;
	logic        DEBUG_RESUME = 1'b0, slow = 1'b0;
	logic [4:0]  OPCODE = 5'h00, DST = 5'h00, SRC = 5'h00;
	logic [2:0]  BITSEL = 3'h0;
	logic [7:0]  IMM = 8'h00;
	logic [5:0]  DISP = 6'h00;
	logic [15:0] ADDR = 16'h0000;
	logic [1:0]  PTR = 2'h0, PTRMODE = 2'h0;
	logic        READY, DMEM_WE, DMEM_RE, CMEM_RE, CMEM_WE, CMEM_DONE;
	logic        SLEEP_REQ, WDOG_RESTART, DEBUG_BREAK, REG_WE, REG_PAIR;
	logic [15:0] DMEM_ADDR, CMEM_ADDR, CMEM_WDATA, STACK_PTR, REG_DATA;
	logic [7:0]  DMEM_WDATA, DMEM_RDATA, CMEM_RDATA, FLAGS;
	logic [4:0]  REG_NUM;
	int          num_errors = 0, samples_checked = 0, cyc = 0;
	logic [31:0] seed = 32'h000054E3;
	logic [7:0]  regs [32];
	logic [7:0]  shadow [256];
	logic [7:0]  flg = 8'h00;
	logic [15:0] sp = cpu_exec_pkg::STACK_TOP_DFLT;

	flag_move_exec dut (.CLOCK(CLOCK), .NRST(NRST), .ISSUE(ISSUE),
		.OPCODE(OPCODE), .DST(DST), .SRC(SRC), .BITSEL(BITSEL), .IMM(IMM),
		.DISP(DISP), .ADDR(ADDR), .PTR(PTR), .PTRMODE(PTRMODE),
		.READY(READY), .DMEM_ADDR(DMEM_ADDR), .DMEM_WDATA(DMEM_WDATA),
		.DMEM_WE(DMEM_WE), .DMEM_RE(DMEM_RE), .DMEM_RDATA(DMEM_RDATA),
		.CMEM_ADDR(CMEM_ADDR), .CMEM_WDATA(CMEM_WDATA), .CMEM_RE(CMEM_RE),
		.CMEM_WE(CMEM_WE), .CMEM_RDATA(CMEM_RDATA), .CMEM_DONE(CMEM_DONE),
		.FLAGS(FLAGS), .STACK_PTR(STACK_PTR), .SLEEP_REQ(SLEEP_REQ),
		.WDOG_RESTART(WDOG_RESTART), .DEBUG_BREAK(DEBUG_BREAK),
		.DEBUG_RESUME(DEBUG_RESUME), .REG_WE(REG_WE), .REG_PAIR(REG_PAIR),
		.REG_NUM(REG_NUM), .REG_DATA(REG_DATA));

	mem_partner mem (.CLOCK(CLOCK), .DMEM_ADDR(DMEM_ADDR),
		.DMEM_WDATA(DMEM_WDATA), .DMEM_WE(DMEM_WE), .DMEM_RE(DMEM_RE),
		.DMEM_RDATA(DMEM_RDATA), .CMEM_ADDR(CMEM_ADDR), .CMEM_RE(CMEM_RE),
		.CMEM_WE(CMEM_WE), .CMEM_RDATA(CMEM_RDATA), .CMEM_DONE(CMEM_DONE),
		.slow(slow));

	initial forever #50 CLOCK = ~CLOCK;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [4:0] lo(int p);
		return cpu_exec_pkg::REG_X_LO + 5'(2 * p);
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// issue at a falling edge, return in the first cycle after it is taken
	task automatic go(logic [4:0] op);
		@(negedge CLOCK);
		OPCODE = op;
		ISSUE = 1'b1;
		@(negedge CLOCK);
		ISSUE = 1'b0;
	endtask

	// bounded wait for idle; n is the number of busy cycles expected
	task automatic fin(int n);
		int c;
		c = 0;
		while (READY !== 1'b1 && c < 30) begin
			@(negedge CLOCK);
			c++;
		end
		chk("busy", 16'(c), 16'(n));
		chk("flags", FLAGS, flg);
	endtask

	task automatic trace(logic [4:0] r, logic [15:0] v, logic pr);
		chk("reg_we", REG_WE, 1'b1);
		chk("reg_pair", REG_PAIR, pr);
		chk("reg_num", REG_NUM, r);
		chk("reg_data", REG_DATA, v);
		regs[r] = v[7:0];
		if (pr)
			regs[r + 5'h01] = v[15:8];
	endtask

	task automatic imm_load(logic [4:0] r, logic [7:0] v);
		DST = r;
		IMM = v;
		go(cpu_exec_pkg::OP_IMM_LOAD);
		trace(r, {8'h00, v}, 1'b0);
		fin(0);
	endtask

	task automatic setp(int p, logic [15:0] v);
		imm_load(lo(p), v[7:0]);
		imm_load(lo(p) + 5'h01, v[15:8]);
	endtask

	task automatic dmem(logic [4:0] op, logic wr, logic [15:0] ea,
		logic upd, logic [4:0] r, logic [15:0] np);
		go(op);
		chk("dmem_addr", DMEM_ADDR, ea);
		chk("dmem_we", DMEM_WE, wr);
		chk("dmem_re", DMEM_RE, !wr);
		if (wr)
			chk("dmem_wdata", DMEM_WDATA, regs[SRC]);
		if (wr)
			shadow[ea[7:0]] = regs[SRC];
		if (upd)
			trace(r, np, 1'b1);
		else
			chk("reg_we", REG_WE, 1'b0);
		fin(1);
		if (!wr)
			trace(DST, {8'h00, shadow[ea[7:0]]}, 1'b0);
	endtask

	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [15:0] a, np;
		logic [7:0]  v;
		logic [4:0]  op;
		logic [31:0] r;
		for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'hA5;
		for (int i = 0; i < 32; i++) regs[i] = 8'h00;
		repeat (20) @(negedge CLOCK);
		NRST = 1'b1;
		chk("ready", READY, 1'b1);
		chk("sp", STACK_PTR, sp);
		for (int i = 0; i < 32; i++) imm_load(5'(i), 8'(rnd()));
		for (int b = 0; b < 8; b++) begin
			BITSEL = 3'(b);
			flg[b] = 1'b1;
			go(cpu_exec_pkg::OP_FLAG_RAISE);
			fin(0);
		end
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			BITSEL = r[2:0];
			flg[r[2:0]] = r[3];
			op = r[3] ? cpu_exec_pkg::OP_FLAG_RAISE : cpu_exec_pkg::OP_FLAG_LOWER;
			go(op);
			fin(0);
			SRC = 5'(rnd());
			BITSEL = 3'(rnd());
			flg[6] = regs[SRC][BITSEL];
			go(cpu_exec_pkg::OP_T_CAPTURE);
			fin(0);
			DST = 5'(rnd());
			BITSEL = 3'(rnd());
			v = regs[DST];
			v[BITSEL] = flg[6];
			go(cpu_exec_pkg::OP_T_DEPOSIT);
			trace(DST, {8'h00, v}, 1'b0);
			fin(0);
			DST = 5'(rnd());
			SRC = 5'(rnd());
			go(cpu_exec_pkg::OP_COPY_BYTE);
			trace(DST, {8'h00, regs[SRC]}, 1'b0);
			fin(0);
			DST = 5'(rnd()) & 5'h1E;
			SRC = 5'(rnd()) & 5'h1E;
			go(cpu_exec_pkg::OP_COPY_PAIR);
			trace(DST, {regs[SRC + 5'h01], regs[SRC]}, 1'b1);
			fin(0);
		end
		for (int p = 0; p < 3; p++)
			for (int m = 0; m < 3; m++)
				for (int w = 0; w < 2; w++) begin
					a = 16'(rnd());
					if (m == 2 && p == 0)
						a = 16'h0000;
					if (m == 1 && p == 2)
						a = 16'hFFFF;
					PTR = 2'(p);
					PTRMODE = 2'(m);
					// pointer loads overwrite DST, so pick it afterwards
					setp(p, a);
					DST = 5'(rnd() % 26);
					SRC = 5'(rnd() % 26);
					np = (m == 1) ? a + 16'h0001 : a - 16'h0001;
					op = w ? cpu_exec_pkg::OP_IND_WRITE : cpu_exec_pkg::OP_IND_READ;
					dmem(op, 1'(w), (m == 2) ? np : a, m != 0, lo(p), np);
				end
		for (int i = 0; i < 8; i++) begin
			PTR = (i % 2) ? cpu_exec_pkg::PTR_Z : cpu_exec_pkg::PTR_Y;
			DISP = (i < 2) ? 6'h3F : 6'(rnd());
			ADDR = 16'(rnd());
			a = 16'(rnd());
			setp(int'(PTR), a);
			DST = 5'(rnd() % 26);
			SRC = 5'(rnd() % 26);
			op = (i < 4) ? cpu_exec_pkg::OP_DISP_READ : cpu_exec_pkg::OP_DISP_WRITE;
			dmem(op, 1'(i / 4), a + {10'h000, DISP}, 1'b0, 5'h00, 16'h0000);
			op = (i < 4) ? cpu_exec_pkg::OP_DIR_READ : cpu_exec_pkg::OP_DIR_WRITE;
			dmem(op, 1'(i / 4), ADDR, 1'b0, 5'h00, 16'h0000);
		end
		for (int i = 0; i < 8; i++) begin
			SRC = 5'(rnd());
			DST = 5'(rnd());
			if (i < 4)
				dmem(cpu_exec_pkg::OP_PUSH, 1'b1, sp, 1'b0, 5'h00, 16'h0000);
			else
				dmem(cpu_exec_pkg::OP_POP, 1'b0, sp + 16'h0001, 1'b0, 5'h00, 16'h0000);
			sp = (i < 4) ? sp - 16'h0001 : sp + 16'h0001;
			chk("sp", STACK_PTR, sp);
		end
		for (int m = 0; m < 3; m++) begin
			a = 16'(rnd());
			PTR = cpu_exec_pkg::PTR_Z;
			PTRMODE = (m == 1) ? cpu_exec_pkg::PM_INC : cpu_exec_pkg::PM_PLAIN;
			setp(2, a);
			DST = 5'(rnd() % 30);
			op = (m == 2) ? cpu_exec_pkg::OP_CODE_READ_R0 : cpu_exec_pkg::OP_CODE_READ;
			go(op);
			chk("cmem_re", CMEM_RE, 1'b1);
			chk("cmem_addr", CMEM_ADDR, a);
			if (m == 1)
				trace(cpu_exec_pkg::REG_Z_LO, a + 16'h0001, 1'b1);
			fin(2);
			v = a[7:0] ^ a[15:8] ^ 8'h3C;
			trace((m == 2) ? cpu_exec_pkg::REG_R0 : DST, {8'h00, v}, 1'b0);
		end
		for (int s = 0; s < 2; s++) begin
			slow = 1'(s);
			imm_load(cpu_exec_pkg::REG_R0, 8'(rnd()));
			imm_load(cpu_exec_pkg::REG_R1, 8'(rnd()));
			a = 16'(rnd());
			setp(2, a);
			go(cpu_exec_pkg::OP_CODE_WRITE);
			chk("cmem_we", CMEM_WE, 1'b1);
			chk("cmem_wdata", CMEM_WDATA, {regs[1], regs[0]});
			chk("cmem_addr", CMEM_ADDR, a);
			fin(s ? 5 : 2);
		end
		go(cpu_exec_pkg::OP_SLEEP);
		chk("sleep", SLEEP_REQ, 1'b1);
		fin(0);
		go(cpu_exec_pkg::OP_WDOG);
		chk("wdog", WDOG_RESTART, 1'b1);
		fin(0);
		BITSEL = 3'h0;
		flg[0] = 1'b0;
		go(cpu_exec_pkg::OP_FLAG_LOWER);
		fin(0);
		go(cpu_exec_pkg::OP_BREAK);
		chk("break", DEBUG_BREAK, 1'b1);
		// an issue during the halt must be ignored
		@(negedge CLOCK);
		OPCODE = cpu_exec_pkg::OP_FLAG_RAISE;
		ISSUE = 1'b1;
		repeat (3) @(negedge CLOCK);
		ISSUE = 1'b0;
		chk("ready", READY, 1'b0);
		DEBUG_RESUME = 1'b1;
		@(negedge CLOCK);
		DEBUG_RESUME = 1'b0;
		fin(0);
		print_verdict();
	end
endmodule
